//--- srcc_top.v
// standby, reset and system clock divider control
`timescale 1ns/1ps
`include "srcc_defs.vh"
module srcc_top
(
    clk,
    rst_n,
    reset_pin_n,
    por_detect,
    opt_por_level,
    uv_detect_lo,
    uv_detect_hi,
    opt_uv_enable,
    opt_uv_sel_hi,
    wdt_reset,
    div_sel,
    xtal_run,
    standby_cmd,
    any_irq,
    ext_irq_pin_0,
    ext_irq_pin_1,
    ext_irq_pin_2,
    ext_irq_pin_3,
    ext_irq_pin_4,
    ext_irq_pin_5,
    ext_irq_level,
    port0_irq,
    spi_irq,
    base_timer_irq,
    rtc_irq,
    sys_reset_n,
    cycle_en,
    core_run,
    periph_run,
    bt_rtc_run,
    osc_en,
    standby_state,
    irq_pending
);
    input  wire                      clk;
    input  wire                      rst_n;
    input  wire                      reset_pin_n;
    input  wire [1:0]                por_detect;
    input  wire                      opt_por_level;
    input  wire                      uv_detect_lo;
    input  wire                      uv_detect_hi;
    input  wire                      opt_uv_enable;
    input  wire                      opt_uv_sel_hi;
    input  wire                      wdt_reset;
    input  wire [`SRCC_DIV_W-1:0]    div_sel;
    input  wire                      xtal_run;
    input  wire [1:0]                standby_cmd;
    input  wire                      any_irq;
    input  wire                      ext_irq_pin_0;
    input  wire                      ext_irq_pin_1;
    input  wire                      ext_irq_pin_2;
    input  wire                      ext_irq_pin_3;
    input  wire                      ext_irq_pin_4;
    input  wire                      ext_irq_pin_5;
    input  wire [5:0]                ext_irq_level;
    input  wire                      port0_irq;
    input  wire                      spi_irq;
    input  wire                      base_timer_irq;
    input  wire                      rtc_irq;
    output reg                       sys_reset_n;
    output reg                       cycle_en;
    output reg                       core_run;
    output reg                       periph_run;
    output reg                       bt_rtc_run;
    output reg  [`SRCC_OSC_W-1:0]    osc_en;
    output reg  [`SRCC_ST_W-1:0]     standby_state;
    output reg                       irq_pending;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [15:0] raw_in;
    wire [15:0] syn;
    assign raw_in = {rtc_irq, base_timer_irq, spi_irq, port0_irq,
                     ext_irq_pin_5, ext_irq_pin_4, ext_irq_pin_3,
                     ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0,
                     uv_detect_hi, uv_detect_lo, por_detect[1],
                     por_detect[0], ~reset_pin_n, wdt_reset};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_sync
            srcc_sync u_sync
            (
                .clk   (clk),
                .rst_n (rst_n),
                .din   (raw_in[gi]),
                .dout  (syn[gi])
            );
        end
    endgenerate

    wire wdt_s   = syn[0];
    wire pin_rst = syn[1];
    wire uv_lo   = syn[4];
    wire uv_hi   = syn[5];
    wire [5:0] ext_s = syn[11:6];
    wire port0_s = syn[12];
    wire spi_s   = syn[13];
    wire bt_s    = syn[14];
    wire rtc_s   = syn[15];

    // ------------------------------------------------------------
    // internal and external (reset pin) reset sources
    // ------------------------------------------------------------
    reg                       por_done;
    reg [`SRCC_RST_CNT_W-1:0] rst_cnt;
    reg                       prev_xtal;

    wire por_active = opt_por_level ? syn[3] : syn[2];
    wire uv_active  = opt_uv_enable & (opt_uv_sel_hi ? uv_hi : uv_lo);
    wire por_cause  = ~por_done & por_active;
    wire any_rst    = por_cause | uv_active | pin_rst | wdt_s;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_done    <= 1'b0;
            rst_cnt     <= `SRCC_RST_HOLD;
            sys_reset_n <= 1'b0;
        end
        else
        begin
            if (!por_active && rst_cnt == `SRCC_ZERO4)
                por_done <= 1'b1;
            if (any_rst)
                rst_cnt <= `SRCC_RST_HOLD;
            else if (rst_cnt != `SRCC_ZERO4)
                rst_cnt <= rst_cnt - `SRCC_ONE4;
            sys_reset_n <= ~any_rst & (rst_cnt == `SRCC_ZERO4);
        end
    end

    // ------------------------------------------------------------
    // system clock divider
    // ------------------------------------------------------------
    reg [`SRCC_DIV_CNT_W-1:0] div_cnt;
    wire [`SRCC_DIV_W-1:0] div_eff =
        (div_sel > `SRCC_DIV_MAX) ? `SRCC_DIV_MAX : div_sel;
    wire [`SRCC_DIV_CNT_W-1:0] div_top =
        (`SRCC_ONE8 << div_eff) - `SRCC_ONE8;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt  <= `SRCC_ZERO8;
            cycle_en <= 1'b0;
        end
        else
        begin
            // divide by 1 to 256 cycles
            if (!core_run || div_cnt >= div_top)
                div_cnt <= `SRCC_ZERO8;
            else
                div_cnt <= div_cnt + `SRCC_ONE8;
            cycle_en <= core_run & (div_cnt >= div_top);
        end
    end

    // ------------------------------------------------------------
    // standby state machine
    // ------------------------------------------------------------
    wire [5:0] ext_hit  = ~(ext_s ^ ext_irq_level);
    wire wake_deep  = (|ext_hit) | port0_s | spi_s;
    wire wake_xkeep = wake_deep | bt_s | rtc_s;
    reg [`SRCC_ST_W-1:0] next_state;

    always @*
    begin
        next_state = standby_state;
        case (standby_state)
            `SRCC_ST_RUN:
                if (standby_cmd == `SRCC_CMD_HALT)
                    next_state = `SRCC_ST_HALT;
                else if (standby_cmd == `SRCC_CMD_DEEP)
                    next_state = `SRCC_ST_DEEP;
                else if (standby_cmd == `SRCC_CMD_XKEEP)
                    next_state = `SRCC_ST_XKEEP;
            `SRCC_ST_HALT:
                if (any_irq | wake_xkeep)
                    next_state = `SRCC_ST_RUN;
            `SRCC_ST_DEEP:
                if (wake_deep)
                    next_state = `SRCC_ST_RUN;
            default:
                if (wake_xkeep)
                    next_state = `SRCC_ST_RUN;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_state <= `SRCC_ST_RUN;
            core_run      <= 1'b0;
            periph_run    <= 1'b0;
            bt_rtc_run    <= 1'b0;
            osc_en        <= `SRCC_OSC_ALL;
            prev_xtal     <= 1'b1;
            irq_pending   <= 1'b0;
        end
        else if (any_rst)
        begin
            // any reset cause (power-on, low voltage, reset pin or watchdog) ends standby
            standby_state <= `SRCC_ST_RUN;
            core_run      <= 1'b0;
            periph_run    <= 1'b0;
            bt_rtc_run    <= 1'b0;
            osc_en        <= `SRCC_OSC_ALL;
            prev_xtal     <= 1'b1;
            irq_pending   <= 1'b0;
        end
        else
        begin
            standby_state <= next_state;
            if (standby_state == `SRCC_ST_RUN &&
                next_state != `SRCC_ST_RUN)
                prev_xtal <= xtal_run;
            if (standby_state != `SRCC_ST_RUN &&
                next_state == `SRCC_ST_RUN)
                irq_pending <= 1'b1;
            else if (standby_state == `SRCC_ST_RUN)
                irq_pending <= 1'b0;
            case (next_state)
                `SRCC_ST_HALT:
                begin
                    core_run   <= 1'b0;
                    periph_run <= 1'b1;
                    bt_rtc_run <= 1'b1;
                    osc_en     <= osc_en;
                end
                `SRCC_ST_DEEP:
                begin
                    core_run   <= 1'b0;
                    periph_run <= 1'b0;
                    bt_rtc_run <= 1'b0;
                    osc_en     <= 4'h0;
                end
                `SRCC_ST_XKEEP:
                begin
                    core_run   <= 1'b0;
                    periph_run <= 1'b0;
                    bt_rtc_run <= 1'b1;
                    osc_en[`SRCC_OSC_CER] <= 1'b0;
                    osc_en[`SRCC_OSC_RC]  <= 1'b0;
                    osc_en[`SRCC_OSC_VRC] <= 1'b0;
                    osc_en[`SRCC_OSC_XTAL] <=
                        (standby_state == `SRCC_ST_RUN) ? xtal_run
                                                       : prev_xtal;
                end
                default:
                begin
                    core_run   <= 1'b1;
                    periph_run <= 1'b1;
                    bt_rtc_run <= 1'b1;
                    osc_en     <= {1'b1, xtal_run, 2'h3};
                end
            endcase
        end
    end
endmodule // srcc_top

//--- srcc_defs.vh
// constants for the standby, reset and clock control block
`ifndef SRCC_DEFS_VH
`define SRCC_DEFS_VH
// divider selections (instruction cycle at 12 MHz main clock)
`define SRCC_DIV_W        4
`define SRCC_DIV_MAX      4'h8
`define SRCC_DIV_CNT_W    8
// standby states
`define SRCC_ST_W         2
`define SRCC_ST_RUN       2'h0
`define SRCC_ST_HALT      2'h1
`define SRCC_ST_DEEP      2'h2
`define SRCC_ST_XKEEP     2'h3
// standby entry commands
`define SRCC_CMD_NONE     2'h0
`define SRCC_CMD_HALT     2'h1
`define SRCC_CMD_DEEP     2'h2
`define SRCC_CMD_XKEEP    2'h3
// oscillator enable bits
`define SRCC_OSC_W        4
`define SRCC_OSC_CER      0
`define SRCC_OSC_RC       1
`define SRCC_OSC_XTAL     2
`define SRCC_OSC_VRC      3
`define SRCC_OSC_ALL      4'hf
// reset stretch after all causes clear
`define SRCC_RST_HOLD     4'hf
`define SRCC_RST_CNT_W    4
`define SRCC_ONE4         4'h1
`define SRCC_ZERO4        4'h0
`define SRCC_ONE8         8'h01
`define SRCC_ZERO8        8'h00
`endif

//--- srcc_sync.v
// three-stage input synchroniser with agreement check
`timescale 1ns/1ps
module srcc_sync
(
    clk,
    rst_n,
    din,
    dout
);
    input  wire clk;
    input  wire rst_n;
    input  wire din;
    output reg  dout;

    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                dout <= s3;
        end
    end
endmodule // srcc_sync

//--- srcc_top_sva.sv
// assertions for the standby, reset and clock control block
`timescale 1ns/1ps
`include "srcc_defs.vh"
module srcc_top_sva
(
    input wire       clk,
    input wire       rst_n,
    input wire       reset_pin_n,
    input wire [3:0] div_sel,
    input wire [1:0] standby_cmd,
    input wire       any_irq,
    input wire       port0_irq,
    input wire       rtc_irq,
    input wire       sys_reset_n,
    input wire       cycle_en,
    input wire       core_run,
    input wire       periph_run,
    input wire       bt_rtc_run,
    input wire [3:0] osc_en,
    input wire [1:0] standby_state,
    input wire       irq_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_run; standby_state == `SRCC_ST_RUN; endsequence
    sequence s_wake; $past(standby_state[1]) ##0 s_run ##0 core_run;
    endsequence
    property p_wake_pend; s_wake |-> irq_pending ##1 !irq_pending;
    endproperty
    a_wake_pend: assert property (p_wake_pend)
        else $error("no single pending pulse on wake");
    property p_deep; standby_state == `SRCC_ST_DEEP |-> osc_en == 4'h0
        && !core_run && !periph_run && !bt_rtc_run; endproperty
    a_deep: assert property (p_deep)
        else $error("deep stop outputs wrong");
    property p_xkeep; standby_state == `SRCC_ST_XKEEP |-> !core_run
        && !periph_run && bt_rtc_run && (osc_en & 4'hb) == 4'h0; endproperty
    a_xkeep: assert property (p_xkeep)
        else $error("crystal keep outputs wrong");
    property p_xtal; standby_state == `SRCC_ST_XKEEP
        && $past(standby_state) == `SRCC_ST_XKEEP |-> $stable(osc_en[2]);
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal enable changed in stop");
    property p_halt; standby_state == `SRCC_ST_HALT |-> !core_run
        && periph_run && $stable(osc_en); endproperty
    a_halt: assert property (p_halt)
        else $error("halt outputs wrong");
    property p_cmd; s_run ##0 core_run && sys_reset_n && standby_cmd != 2'h0
        |=> standby_state == $past(standby_cmd); endproperty
    a_cmd: assert property (p_cmd)
        else $error("standby command not taken");
    property p_deep_wake; standby_state == `SRCC_ST_DEEP && port0_irq
        |-> ##[1:6] s_run; endproperty
    a_deep_wake: assert property (p_deep_wake)
        else $error("deep stop did not wake");
    property p_xk_wake; standby_state == `SRCC_ST_XKEEP && rtc_irq
        |-> ##[1:6] s_run; endproperty
    a_xk_wake: assert property (p_xk_wake)
        else $error("crystal keep did not wake");
    property p_halt_wake; standby_state == `SRCC_ST_HALT && any_irq
        |-> ##[1:6] s_run; endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("halt did not end");
    property p_div; cycle_en && div_sel == 4'h2 |-> core_run
        ##1 !cycle_en [*3]; endproperty
    a_div: assert property (p_div)
        else $error("divider pulse spacing wrong");
    property p_pin; !reset_pin_n |-> ##[1:6] !sys_reset_n; endproperty
    a_pin: assert property (p_pin)
        else $error("reset pin ignored");
endmodule // srcc_top_sva
bind srcc_top srcc_top_sva srcc_top_sva_i (.*);

//--- srcc_wake_model.sv
// wake source model: interrupt flags held until the core runs again
`timescale 1ns/1ps
module srcc_wake_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] src,
    input  wire logic       core_run,
    output logic      [9:0] line
);
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            line <= 10'h000;
        else if (src != 4'h0)
            line[src - 4'h1] <= 1'b1;
        else if (core_run)
            line <= 10'h000;
endmodule // srcc_wake_model

//--- srcc_top_tb_top.sv
// testbench for the standby, reset and clock control block
`timescale 1ns/1ps
`include "srcc_defs.vh"
module srcc_top_tb_top;
    logic clk = 0, rst_n = 0, reset_pin_n = 1, opt_por_level = 0;
    logic uv_lo = 0, uv_hi = 0, uv_en = 1, uv_hi_sel = 0, wdt = 0;
    logic xtal_run = 1, any_irq = 0, sys_reset_n, cycle_en, core_run;
    logic periph_run, bt_rtc_run, irq_pending, o;
    logic [1:0] por_detect = 2'h3, cmd_v = 2'h0, standby_state;
    logic [3:0] div_sel = 4'h0, src = 4'h0, osc_en, saved;
    logic [5:0] lvl = 6'h15, pins;
    logic [9:0] line;
    int n_mismatch = 0, total_checks = 0, cyc = 0, i, n, d, s;
    assign pins = ~(line[5:0] ^ lvl);
    always #10 clk = ~clk;
    srcc_wake_model srcc_wake_model_i (.clk(clk), .rst_n(rst_n),
        .src(src), .core_run(core_run), .line(line));
    srcc_top srcc_top_i (.clk(clk), .rst_n(rst_n),
        .reset_pin_n(reset_pin_n), .por_detect(por_detect),
        .opt_por_level(opt_por_level), .uv_detect_lo(uv_lo),
        .uv_detect_hi(uv_hi), .opt_uv_enable(uv_en),
        .opt_uv_sel_hi(uv_hi_sel), .wdt_reset(wdt), .div_sel(div_sel),
        .xtal_run(xtal_run), .standby_cmd(cmd_v), .any_irq(any_irq),
        .ext_irq_pin_0(pins[0]), .ext_irq_pin_1(pins[1]),
        .ext_irq_pin_2(pins[2]), .ext_irq_pin_3(pins[3]),
        .ext_irq_pin_4(pins[4]), .ext_irq_pin_5(pins[5]),
        .ext_irq_level(lvl), .port0_irq(line[6]), .spi_irq(line[7]),
        .base_timer_irq(line[8]), .rtc_irq(line[9]),
        .sys_reset_n(sys_reset_n), .cycle_en(cycle_en),
        .core_run(core_run), .periph_run(periph_run),
        .bt_rtc_run(bt_rtc_run), .osc_en(osc_en),
        .standby_state(standby_state), .irq_pending(irq_pending));
    task conclude;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wait_rst(input logic v);
        for (i = 0; i < 40 && sys_reset_n !== v; i++) @(negedge clk);
        chk(sys_reset_n, v);
    endtask
    task wait_st(input logic [1:0] e);
        for (i = 0; i < 12 && standby_state !== e; i++) @(negedge clk);
        chk(standby_state, e);
    endtask
    task go(input logic [1:0] c);
        repeat (6) @(negedge clk);
        cmd_v = c;
        @(negedge clk);
        cmd_v = 2'h0;
        chk(standby_state, c);
    endtask
    task wake(input logic [3:0] k);
        src = k;
        @(negedge clk);
        src = 4'h0;
    endtask
    task hold_ok;
        repeat (20) @(negedge clk);
        chk(sys_reset_n, 1'b1);
    endtask
    always @(posedge clk)
        if (++cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (30) @(negedge clk);
        chk(sys_reset_n, 1'b0);
        por_detect = 2'h2;
        wait_rst(1'b1);
        for (d = 0; d < 10; d++)
        begin
            div_sel = d[3:0];
            repeat (2) for (i = 0; i < 600 && cycle_en !== 1; i++)
                @(negedge clk);
            @(negedge clk);
            for (n = 1; n < 600 && cycle_en !== 1; n++) @(negedge clk);
            chk(n, 16'h1 << (d > 8 ? 8 : d));
        end
        saved = osc_en;
        go(2'h1);
        chk({core_run, periph_run, osc_en}, {2'h1, saved});
        any_irq = 1;
        wait_st(2'h0);
        any_irq = 0;
        go(2'h1);
        wdt = 1;
        wait_st(2'h0);
        wait_rst(1'b0);
        wdt = 0;
        wait_rst(1'b1);
        for (s = 1; s < 9; s++)
        begin
            go(2'h2);
            chk(osc_en, 4'h0);
            wake(s[3:0]);
            wait_st(2'h0);
            chk({irq_pending, core_run}, 2'h3);
        end
        go(2'h2);
        wake(4'h9);
        repeat (10) @(negedge clk);
        chk(standby_state, 2'h2);
        wake(4'h7);
        wait_st(2'h0);
        for (s = 0; s < 2; s++)
        begin
            xtal_run = s[0];
            repeat (2) @(negedge clk);
            o = osc_en[2];
            go(2'h3);
            chk({osc_en[2], bt_rtc_run}, {o, 1'b1});
            chk(osc_en & 4'hb, 4'h0);
            wake(4'h9 + s[3:0]);
            wait_st(2'h0);
        end
        go(2'h2);
        reset_pin_n = 0;
        wait_st(2'h0);
        wait_rst(1'b0);
        reset_pin_n = 1;
        wait_rst(1'b1);
        uv_lo = 1;
        wait_rst(1'b0);
        uv_lo = 0;
        wait_rst(1'b1);
        uv_en = 0;
        uv_lo = 1;
        hold_ok();
        uv_en = 1;
        uv_hi_sel = 1;
        hold_ok();
        uv_hi = 1;
        wait_rst(1'b0);
        {uv_hi, uv_lo} = 2'h0;
        wait_rst(1'b1);
        por_detect = 2'h1;
        hold_ok();
        conclude();
    end
endmodule // srcc_top_tb_top
